// ===== rtl/sec_counters.sv
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// RULE1 - Update at one second, 42ms, 62.5ms, manual
// RULE2 - Every counter saturates, never wraps
// RULE3 - Select internal second or manual update input
// RULE4 - Raise timer event at each automatic update
// RULE5 - Same-polarity successive marks count as violation
// RULE6 - Valid substitution codewords are not violations
// RULE7 - E1 select counts code violations instead
// RULE8 - Line counter ignores sync loss, saturates 65535
// RULE9 - T1 optionally counts excessive zero runs
// RULE10 - T1 path counts CRC-6, Ft, optional Fs
// RULE11 - T1 path counter halts during frame loss
// RULE12 - E1 path counter counts CRC-4 errors
// RULE13 - E1 path and E-bit halt on FAS/CRC loss
// RULE14 - Counters are 16 bits, high then low; only the line counter is split, path, OOS and E-bit read as one 16-bit word
// RULE15 - T1 option counts unsynced multiframes always
// RULE16 - T1 F-bit option counts pattern errors
// RULE17 - E1 counts FAS word errors when synced
// RULE18 - E1 E-bit counter counts zero E-bits
// RULE19 - E-bit counter idle in T1 mode
// RULE20 - Update copies accumulators, then clears them
module sec_counters #(
  parameter int SEC_COUNT = sec_pkg::SEC_CYC,
  parameter int T1_FAST_COUNT = sec_pkg::T1_FAST_CYC,
  parameter int E1_FAST_COUNT = sec_pkg::E1_FAST_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Receive line decoder events, one-cycle pulses
  input wire logic rx_pulse_i,
  input wire logic rx_pol_i,
  input wire logic rx_bit_i,
  input wire logic rx_bit_valid_i,
  input wire logic zsub_code_i,
  // Framer events and status
  input wire logic crc_err_i,
  input wire logic ft_err_i,
  input wire logic fs_err_i,
  input wire logic fps_err_i,
  input wire logic fas_err_i,
  input wire logic mf_tick_i,
  input wire logic ebit_valid_i,
  input wire logic ebit_i,
  input wire logic rx_frame_loss_i,
  input wire logic fas_search_i,
  input wire logic crc_sync_loss_i,
  input wire logic cas_search_i,
  input wire logic manual_update_i,
  output logic timer_event_o
);
  initial begin
    if (SEC_COUNT < 2 || T1_FAST_COUNT < 2 || E1_FAST_COUNT < 2) begin
      $error("sec_counters: bad timer counts");
    end
    if (T1_FAST_COUNT > SEC_COUNT || E1_FAST_COUNT > SEC_COUNT) begin
      $error("sec_counters: fast period longer than one second");
    end
    // The period counter is 25 bits wide
    if (SEC_COUNT > 33554432) begin
      $error("sec_counters: one-second count too large for the timer");
    end
  end

  typedef struct packed {
    logic [sec_pkg::CFG_W-1:0] cfg;
    logic timer_flag;
    logic [24:0] timer;
    logic last_pol;
    logic last_bpv_pol;
    logic have_mark;
    logic have_bpv;
    logic [4:0] zrun;
    logic [15:0] acc_lv;
    logic [15:0] acc_path;
    logic [15:0] acc_oos;
    logic [15:0] acc_fe;
    logic [15:0] lv;
    logic [15:0] path;
    logic [15:0] oos;
    logic [15:0] fe;
    logic man_d;
    logic ack;
    logic [31:0] rdata;
    logic tevent;
  } sec_state_s;

  sec_state_s cur;
  sec_state_s next_cur;

  // Saturating add of one
  function automatic logic [15:0] sat_inc(input logic [15:0] v,
                                           input logic en);
    sat_inc = (en && v != sec_pkg::CNT_MAX) ? v + 16'h0001 : v; // RULE2
  endfunction

  function automatic logic [24:0] period(input logic [7:0] c);
    if (!c[sec_pkg::CFG_RATE]) begin
      period = 25'(SEC_COUNT - 1);
    end else if (c[sec_pkg::CFG_E1]) begin
      period = 25'(E1_FAST_COUNT - 1);
    end else begin
      period = 25'(T1_FAST_COUNT - 1);
    end
  endfunction

  // Zero-run length that counts as excessive, by substitution mode
  function automatic logic [4:0] zero_limit(input logic [7:0] c);
    if (c[sec_pkg::CFG_ZSUB]) begin
      zero_limit = 5'(sec_pkg::EXZ_SUBST); // RULE9
    end else begin
      zero_limit = 5'(sec_pkg::EXZ_PLAIN);
    end
  endfunction

  // Zero-run step: returns {excessive run seen, next run length}.
  // The run restarts after each count, so a long string of zeros
  // is counted once per threshold length.
  function automatic logic [5:0] zero_step(
    input logic [4:0] run,
    input logic [4:0] limit,
    input logic bit_valid,
    input logic bit_one
  );
    zero_step = {1'b0, run};
    if (bit_valid) begin
      if (bit_one) begin
        zero_step = 6'h00;
      end else if (run + 5'h01 >= limit) begin
        zero_step = {1'b1, 5'h00}; // RULE9
      end else begin
        zero_step = {1'b0, run + 5'h01};
      end
    end
  endfunction

  // Line counter event; it never looks at sync loss
  function automatic logic line_event(
    input logic [7:0] c,
    input logic bpv_hit,
    input logic cv_hit,
    input logic exz_hit
  );
    if (c[sec_pkg::CFG_E1]) begin
      line_event = c[sec_pkg::CFG_CV_EXZ] ? cv_hit : bpv_hit; // RULE7
    end else begin
      line_event = bpv_hit || (c[sec_pkg::CFG_CV_EXZ] && exz_hit); // RULE9
    end
  endfunction

  // Path counter event; frame or multiframe loss freezes it
  function automatic logic path_event(
    input logic [7:0] c,
    input logic crc,
    input logic ft,
    input logic fs,
    input logic loss,
    input logic fas_hunt,
    input logic crc_lost
  );
    if (c[sec_pkg::CFG_E1]) begin
      path_event = crc && !fas_hunt && !crc_lost; // RULE12 RULE13
    end else if (loss) begin
      path_event = 1'b0; // RULE11
    end else if (c[sec_pkg::CFG_ESF]) begin
      path_event = crc; // RULE10
    end else begin
      path_event = ft || (c[sec_pkg::CFG_FS] && fs); // RULE10
    end
  endfunction

  // Out-of-sync counter event
  function automatic logic oos_event(
    input logic [7:0] c,
    input logic ft,
    input logic fps,
    input logic fas,
    input logic mf,
    input logic loss,
    input logic fas_hunt,
    input logic cas_hunt,
    input logic crc_lost
  );
    if (c[sec_pkg::CFG_E1]) begin
      oos_event = fas && !loss && !fas_hunt && !cas_hunt &&
                  !crc_lost; // RULE17
    end else if (!c[sec_pkg::CFG_FBIT]) begin
      // Whole multiframes spent unsynchronised, so loss must not gate it
      oos_event = mf && loss; // RULE15
    end else if (loss) begin
      oos_event = 1'b0; // RULE16
    end else begin
      oos_event = c[sec_pkg::CFG_ESF] ? fps : ft; // RULE16
    end
  endfunction

  // Far-end block error event, E1 only
  function automatic logic fe_event(
    input logic [7:0] c,
    input logic valid,
    input logic ebit,
    input logic fas_hunt,
    input logic crc_lost
  );
    if (!c[sec_pkg::CFG_E1]) begin
      fe_event = 1'b0; // RULE19
    end else begin
      fe_event = valid && !ebit && !fas_hunt && !crc_lost; // RULE13 RULE18
    end
  endfunction

  // One counter step, returns {next accumulator, next shown count}.
  // On update the shown count takes the accumulator plus this cycle's event.
  function automatic logic [31:0] roll(
    input logic [15:0] acc,
    input logic [15:0] shown,
    input logic ev,
    input logic update
  );
    if (update) begin
      roll = {16'h0000, sat_inc(acc, ev)}; // RULE20
    end else begin
      roll = {sat_inc(acc, ev), shown};
    end
  endfunction

  // Register read multiplexer; unmapped offsets read as zero
  function automatic logic [31:0] read_word(
    input logic [4:0] a,
    input sec_state_s s
  );
    case (a)
      sec_pkg::OFF_CONFIG: read_word = {24'h000000, s.cfg};
      sec_pkg::OFF_STATUS: read_word = {31'h00000000, s.timer_flag};
      sec_pkg::OFF_LV_HI: read_word = {24'h000000, s.lv[15:8]}; // RULE14
      sec_pkg::OFF_LV_LO: read_word = {24'h000000, s.lv[7:0]};
      sec_pkg::OFF_PATH: read_word = {16'h0000, s.path};
      sec_pkg::OFF_OOS: read_word = {16'h0000, s.oos};
      sec_pkg::OFF_FE: read_word = {16'h0000, s.fe};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  logic bus_req;
  logic upd;
  logic auto_upd;
  logic bpv;
  logic cv;
  logic exz;
  logic lv_ev;
  logic path_ev;
  logic oos_ev;
  logic fe_ev;
  logic [4:0] zlim;
  logic [31:0] rd;

  always_comb begin
    next_cur = cur;
    // Ack gates the take, so a request still held during ack is served once
    bus_req = cyc_i && stb_i && !cur.ack;
    // Automatic timer, restarted whenever the period choice changes
    auto_upd = 1'b0;
    if (cur.timer >= period(cur.cfg)) begin
      next_cur.timer = '0;
      auto_upd = 1'b1;
    end else begin
      next_cur.timer = cur.timer + 25'h0000001;
    end
    // Edge detector idles low like the input, so reset makes no update
    next_cur.man_d = manual_update_i;
    upd = cur.cfg[sec_pkg::CFG_MAN] ?
          (manual_update_i && !cur.man_d) : auto_upd; // RULE1 RULE3
    next_cur.tevent = upd && !cur.cfg[sec_pkg::CFG_MAN]; // RULE4
    // Line violations
    bpv = 1'b0;
    cv = 1'b0;
    if (rx_pulse_i) begin
      bpv = cur.have_mark && rx_pol_i == cur.last_pol &&
            !(cur.cfg[sec_pkg::CFG_ZSUB] && zsub_code_i); // RULE5 RULE6
      next_cur.last_pol = rx_pol_i;
      next_cur.have_mark = 1'b1;
      if (bpv) begin
        cv = cur.have_bpv && rx_pol_i == cur.last_bpv_pol; // RULE7
        next_cur.last_bpv_pol = rx_pol_i;
        next_cur.have_bpv = 1'b1;
      end
    end
    zlim = zero_limit(cur.cfg);
    {exz, next_cur.zrun} = zero_step(cur.zrun, zlim, rx_bit_valid_i,
                                     rx_bit_i);
    lv_ev = line_event(cur.cfg, bpv, cv, exz); // RULE8
    path_ev = path_event(cur.cfg, crc_err_i, ft_err_i, fs_err_i,
                         rx_frame_loss_i, fas_search_i, crc_sync_loss_i);
    oos_ev = oos_event(cur.cfg, ft_err_i, fps_err_i, fas_err_i, mf_tick_i,
                       rx_frame_loss_i, fas_search_i, cas_search_i,
                       crc_sync_loss_i);
    fe_ev = fe_event(cur.cfg, ebit_valid_i, ebit_i, fas_search_i,
                     crc_sync_loss_i);
    // An event in the update cycle lands in the shown count, not lost
    {next_cur.acc_lv, next_cur.lv} = roll(cur.acc_lv, cur.lv, lv_ev, upd);
    {next_cur.acc_path, next_cur.path} =
      roll(cur.acc_path, cur.path, path_ev, upd);
    {next_cur.acc_oos, next_cur.oos} = roll(cur.acc_oos, cur.oos, oos_ev, upd);
    {next_cur.acc_fe, next_cur.fe} = roll(cur.acc_fe, cur.fe, fe_ev, upd);
    // Timer flag: a new automatic update beats a software clear in the same cycle
    if (bus_req && we_i && adr_i == sec_pkg::OFF_STATUS && sel_i[0] &&
        dat_i[sec_pkg::ST_TIMER]) begin
      next_cur.timer_flag = 1'b0;
    end
    if (next_cur.tevent) begin
      next_cur.timer_flag = 1'b1; // RULE4
    end
    if (bus_req && we_i && adr_i == sec_pkg::OFF_CONFIG && sel_i[0]) begin
      next_cur.cfg = dat_i[sec_pkg::CFG_W-1:0];
      if (dat_i[sec_pkg::CFG_W-1:0] != cur.cfg) begin
        next_cur.timer = '0;
      end
    end
    rd = read_word(adr_i, cur);
    next_cur.ack = bus_req;
    next_cur.rdata = bus_req ? rd : cur.rdata;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.cfg <= sec_pkg::CFG_RESET;
      cur.timer_flag <= sec_pkg::ST_RESET[sec_pkg::ST_TIMER];
    end else begin
      cur <= next_cur;
    end
  end

  assign ack_o = cur.ack;
  assign dat_o = cur.rdata;
  assign timer_event_o = cur.tevent;
endmodule

// ===== rtl/sec_pkg.sv
package sec_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [4:0] OFF_CONFIG = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_LV_HI = 5'h08;
  localparam logic [4:0] OFF_LV_LO = 5'h0C;
  localparam logic [4:0] OFF_PATH = 5'h10;
  localparam logic [4:0] OFF_OOS = 5'h14;
  localparam logic [4:0] OFF_FE = 5'h18;
  // Counter configuration fields
  localparam int CFG_CV_EXZ = 0;
  localparam int CFG_FBIT = 1;
  localparam int CFG_FS = 2;
  localparam int CFG_E1 = 3;
  localparam int CFG_ESF = 4;
  localparam int CFG_ZSUB = 5;
  localparam int CFG_MAN = 6;
  localparam int CFG_RATE = 7;
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Status fields
  localparam int ST_TIMER = 0;
  localparam logic [31:0] ST_RESET = 32'h0000_0000;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SEC_MS = 1000;
  localparam int T1_FAST_US = 42_000;
  localparam int E1_FAST_US = 62_500;
  localparam int SEC_CYC = CLK_HZ;
  localparam int T1_FAST_CYC = (CLK_HZ / 1000) * (T1_FAST_US / 1000);
  localparam int E1_FAST_CYC = (CLK_HZ / 1000) * E1_FAST_US / 1000;
  // Zero-run thresholds for excessive zero counting
  localparam int EXZ_PLAIN = 16;
  localparam int EXZ_SUBST = 8;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage

// ===== verification/sec_counters_sva.sv
`timescale 1ns/1ns
module sec_counters_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic timer_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence read_s;
    take_s ##0 !we_i;
  endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (take_s |=> ack_o)
    else $error("access not answered");
  a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  a_data_hold: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
    else $error("read data moved while idle");
  a_timer_gap: assert property (timer_event_o |=> !timer_event_o [*8])
    else $error("timer event too close");
  a_unmapped_zero: assert property (
    read_s ##0 adr_i == 5'h1C |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_byte_split: assert property (
    read_s ##0 adr_i[4:3] == 2'h1 |=> dat_o[31:8] == 24'h0)
    else $error("line count half too wide");
  a_word_width: assert property (
    read_s ##0 adr_i[4] |=> dat_o[31:16] == 16'h0)
    else $error("count wider than 16 bits");
endmodule
bind sec_counters sec_counters_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .timer_event_o(timer_event_o));

// ===== verification/sec_framer_model.sv
`timescale 1ns/1ns
module sec_framer_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [3:0] kind_i,
  input wire logic [16:0] num_i,
  output logic [6:0] ev_o,
  output logic pol_o,
  output logic ebit_o
);
  typedef struct packed {
    logic [16:0] n;
    logic [3:0] k;
    logic t;
  } sec_fm_s;
  sec_fm_s st;
  sec_fm_s next_st;
  logic act;
  assign act = st.n != 17'h0;
  // Idle polarity and E-bit lines toggle so a stale value never looks like a real event; event lines idle low
  assign ev_o = act ? 7'h01 << ((st.k == 4'h7) ? 4'h6 : st.k) : 7'h00;
  assign pol_o = act ? 1'h1 : st.t;
  assign ebit_o = act ? (st.k == 4'h7) : st.t;
  always_comb begin
    next_st = st;
    next_st.t = ~st.t;
    if (act) begin
      next_st.n = st.n - 17'h1;
    end
    if (start_i) begin
      next_st.n = num_i;
      next_st.k = kind_i;
    end
  end
  always_ff @(posedge clk_i) begin
    st <= rst_i ? '0 : next_st;
  end
endmodule

// ===== verification/sec_counters_tb.sv
`timescale 1ns/1ns
module sec_counters_tb;
  logic clk_i, rst_i, cyc, stb, we, ack, tev, man, loss, fsr, crl, cas;
  logic start, pol, eb, zs, bv, bone;
  logic [3:0] sel;
  logic [4:0] adr;
  logic [31:0] dat, rdat, q;
  logic [3:0] kind;
  logic [16:0] num;
  logic [6:0] ev;
  logic [7:0] cf [3] = '{8'h00, 8'h80, 8'h88};
  int per [3] = '{50, 20, 30};
  int error_cnt, total_checks, k;
  sec_counters #(.SEC_COUNT(50), .T1_FAST_COUNT(20), .E1_FAST_COUNT(30)) uut
    (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .rx_pulse_i(ev[0]), .rx_pol_i(pol), .rx_bit_i(bone),
    .rx_bit_valid_i(bv), .zsub_code_i(zs), .crc_err_i(ev[1]),
    .ft_err_i(ev[2]), .fs_err_i(ev[3]), .fps_err_i(1'h0),
    .fas_err_i(ev[4]), .mf_tick_i(ev[5]), .ebit_valid_i(ev[6]),
    .ebit_i(eb), .rx_frame_loss_i(loss), .fas_search_i(fsr),
    .crc_sync_loss_i(crl), .cas_search_i(cas), .manual_update_i(man),
    .timer_event_o(tev));
  sec_framer_model far (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
    .kind_i(kind), .num_i(num), .ev_o(ev), .pol_o(pol), .ebit_o(eb));
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    // Ack is sampled at the edge; no fixed latency is assumed
    do @(posedge clk_i); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task send(input int t, input int n);
    start <= 1'h1;
    kind <= 4'(t);
    num <= 17'(n);
    @(posedge clk_i);
    start <= 1'h0;
    repeat (n + 3) @(posedge clk_i);
  endtask
  task upd;
    man <= 1'h1;
    @(posedge clk_i);
    man <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task zb(input int n, input logic v);
    bone <= v;
    repeat (n) @(posedge clk_i);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    error_cnt++;
    stop_test;
  end
  initial begin
    {rst_i, cyc, stb, we, man, loss, fsr, crl, cas, start} = 10'h200;
    {adr, dat, kind, num} = '0;
    {zs, bv, bone} = 3'h0;
    sel = 4'hF;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(sec_pkg::OFF_CONFIG, 32'h0);
    rd(sec_pkg::OFF_STATUS, 32'h0);
    wb(1'h1, sec_pkg::OFF_CONFIG, 32'h40);
    send(0, 1);
    upd;
    send(0, 4);
    send(2, 2);
    send(3, 1);
    send(6, 2);
    loss <= 1'h1;
    send(2, 3);
    send(5, 2);
    send(0, 1);
    loss <= 1'h0;
    upd;
    rd(sec_pkg::OFF_LV_HI, 32'h0);
    rd(sec_pkg::OFF_LV_LO, 32'h5);
    rd(sec_pkg::OFF_PATH, 32'h2);
    rd(sec_pkg::OFF_OOS, 32'h2);
    rd(sec_pkg::OFF_FE, 32'h0);
    rd(5'h1C, 32'h0);
    upd;
    rd(sec_pkg::OFF_PATH, 32'h0);
    wb(1'h1, sec_pkg::OFF_CONFIG, 32'h48);
    cas <= 1'h1;
    send(1, 3);
    send(6, 2);
    send(7, 1);
    cas <= 1'h0;
    fsr <= 1'h1;
    send(1, 2);
    send(6, 1);
    fsr <= 1'h0;
    crl <= 1'h1;
    send(1, 1);
    crl <= 1'h0;
    send(4, 1);
    upd;
    rd(sec_pkg::OFF_PATH, 32'h3);
    rd(sec_pkg::OFF_FE, 32'h2);
    rd(sec_pkg::OFF_OOS, 32'h1);
    wb(1'h1, sec_pkg::OFF_CONFIG, 32'h41);
    bv <= 1'h1;
    zb(47, 1'h0);
    zb(1, 1'h1);
    zb(15, 1'h0);
    zb(1, 1'h1);
    bv <= 1'h0;
    upd;
    rd(sec_pkg::OFF_LV_LO, 32'h2);
    wb(1'h1, sec_pkg::OFF_CONFIG, 32'h61);
    sel <= 4'hE;
    wb(1'h1, sec_pkg::OFF_CONFIG, 32'hFF);
    sel <= 4'hF;
    rd(sec_pkg::OFF_CONFIG, 32'h61);
    zs <= 1'h1;
    send(0, 2);
    zs <= 1'h0;
    bv <= 1'h1;
    zb(24, 1'h0);
    bv <= 1'h0;
    upd;
    rd(sec_pkg::OFF_LV_LO, 32'h3);
    wb(1'h1, sec_pkg::OFF_CONFIG, 32'h40);
    send(0, 65540);
    upd;
    rd(sec_pkg::OFF_LV_HI, 32'hFF);
    rd(sec_pkg::OFF_LV_LO, 32'hFF);
    foreach (cf[i]) begin
      wb(1'h1, sec_pkg::OFF_CONFIG, {24'h0, cf[i]});
      for (k = 0; k < 300 && tev !== 1'h1; k++) @(posedge clk_i);
      k = 0;
      do begin
        @(posedge clk_i);
        k++;
      end while (k < 300 && tev !== 1'h1);
      chk(k, per[i]);
      wb(1'h0, sec_pkg::OFF_STATUS, 32'h0);
      chk(32'(q[0]), 32'h1);
      wb(1'h1, sec_pkg::OFF_STATUS, 32'h1);
      rd(sec_pkg::OFF_STATUS, 32'h0);
    end
    stop_test;
  end
endmodule
